// ---- src/dma_pkg.sv ----
// Constants shared by the legacy transfer controller
package dma_pkg;

	// ****************************************
	// I/O decode
	// ****************************************
	localparam logic [11:0] MST_PAGE     = 12'h000;
	localparam logic [10:0] SLV_PAGE     = 11'h006;
	localparam logic [3:0]  OFF_CMD_STAT = 4'h8;
	localparam logic [3:0]  OFF_REQ      = 4'h9;
	localparam logic [3:0]  OFF_SMASK    = 4'hA;
	localparam logic [3:0]  OFF_MODE     = 4'hB;
	localparam logic [3:0]  OFF_CLR_PTR  = 4'hC;
	localparam logic [3:0]  OFF_MCLR     = 4'hD;
	localparam logic [3:0]  OFF_CLR_MASK = 4'hE;
	localparam logic [3:0]  OFF_ALL_MASK = 4'hF;

	// ****************************************
	// Fields and codes
	// ****************************************
	localparam int          CMD_DIS_BIT  = 2;
	localparam int          MASK_SET_BIT = 2;
	localparam int          M_SVC        = 3;
	localparam int          M_AUTO       = 2;
	localparam int          M_TYPE       = 0;
	localparam logic [1:0]  SVC_DEMAND   = 2'h0;
	localparam logic [1:0]  SVC_SINGLE   = 2'h1;
	localparam logic [1:0]  TYPE_VERIFY  = 2'h0;
	localparam logic [1:0]  TYPE_WRITE   = 2'h1;
	localparam logic [1:0]  TYPE_READ    = 2'h2;
	localparam logic [1:0]  TYPE_ILLEGAL = 2'h3;
	localparam logic [2:0]  CASCADE_CH   = 3'h4;

	// ****************************************
	// Reset values and item layout
	// ****************************************
	localparam logic [15:0] REG16_RESET  = 16'h0000;
	localparam logic [4:0]  MODE_RESET   = 5'h00;
	localparam logic [3:0]  MASK_RESET   = 4'hF;
	localparam logic [7:0]  RDATA_RESET  = 8'h00;
	localparam int          ITEM_W       = 23;

endpackage : dma_pkg

// ---- src/legacy_transfer_controller.sv ----
// Legacy transfer controller with its item FIFO
`timescale 1ns/1ps

module item_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("item_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;

	assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
	assign out_valid = (wr_r != rd_r);
	assign out_data  = mem[rd_r[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_r <= wr_r + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_r <= rd_r + 1'b1;
			end
		end
	end

endmodule : item_fifo

module legacy_transfer_controller
	import dma_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Legacy I/O port
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic [7:0]       io_rdata,
	// Peripheral requests
	input  wire logic [7:0]  dma_req,
	// Transfer items
	output logic             xfer_valid,
	input  wire logic        xfer_ready,
	output logic [15:0]      xfer_addr,
	output logic [2:0]       xfer_chan,
	output logic [1:0]       xfer_type,
	output logic             xfer_wide,
	output logic             xfer_last,
	// Bus mastership
	output logic             bus_master_grant
);
	typedef enum logic [1:0] {IDLE, XFER, MASTER} state_type;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ****************************************
	// Decode
	// ****************************************
	function automatic logic [5:0] decode(input logic [15:0] a);
		if (a[15:4] == MST_PAGE) begin
			decode = {2'b10, a[3:0]};
		end else if (a[15:5] == SLV_PAGE && !a[0]) begin
			decode = {2'b11, a[4:1]};
		end else begin
			decode = 6'h00;
		end
	endfunction : decode

	function automatic logic [2:0] lowest(input logic [7:0] v);
		lowest = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				lowest = 3'(i);
			end
		end
	endfunction : lowest

	logic [5:0] dec;
	logic       ctl;
	logic [3:0] off;
	logic       wr;
	logic       rd;
	logic [2:0] ch_w;
	logic [2:0] ch_d;

	assign dec  = decode(io_addr);
	assign ctl  = dec[4];
	assign off  = dec[3:0];
	assign wr   = io_wr && dec[5];
	assign rd   = io_rd && dec[5];
	assign ch_w = {ctl, off[2:1]};
	assign ch_d = {ctl, io_wdata[1:0]};

	// ****************************************
	// State
	// ****************************************
	logic [15:0] base_addr_r [8];
	logic [15:0] base_cnt_r  [8];
	logic [15:0] cur_addr_r  [8];
	logic [15:0] cur_cnt_r   [8];
	logic [4:0]  mode_r      [8];
	logic [1:0]  cmd_dis_r;
	logic [7:0]  mask_r;
	logic [7:0]  tc_r;
	logic [1:0]  ptr_r;
	logic [7:0]  rdata_r;
	logic [7:0]  req_meta_r;
	logic [7:0]  req_s_r;
	logic        grant_r;
	logic [2:0]  act_r;
	state_type   st_r;

	logic [7:0]        elig;
	logic [2:0]        win;
	logic [4:0]        act_mode;
	logic              tc_now;
	logic              push;
	logic              in_ready;
	logic [1:0]        push_type;
	logic [15:0]       act_addr;
	logic [ITEM_W-1:0] item;
	logic [ITEM_W-1:0] out_item;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_meta_r <= 8'h00;
			req_s_r    <= 8'h00;
		end else begin
			req_meta_r <= dma_req;
			req_s_r    <= req_meta_r;
		end
	end

	for (genvar i = 0; i < 8; i++) begin : g_elig
		assign elig[i] = req_s_r[i] && !mask_r[i] && !cmd_dis_r[i / 4];
	end

	assign win       = lowest(elig);
	assign act_mode  = mode_r[act_r];
	assign act_addr  = cur_addr_r[act_r];
	assign tc_now    = (cur_cnt_r[act_r] == REG16_RESET);
	assign push      = (st_r == XFER) && in_ready;
	assign push_type = (act_mode[M_TYPE+:2] == TYPE_ILLEGAL) ? TYPE_VERIFY : act_mode[M_TYPE+:2];
	assign item      = {act_r[2], tc_now, push_type, act_r, act_addr};

	// ****************************************
	// Channel address and count
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 8; i++) begin
				base_addr_r[i] <= REG16_RESET;
				base_cnt_r[i]  <= REG16_RESET;
				cur_addr_r[i]  <= REG16_RESET;
				cur_cnt_r[i]   <= REG16_RESET;
			end
		end else begin
			if (push) begin
				if (tc_now && act_mode[M_AUTO]) begin
					cur_addr_r[act_r] <= base_addr_r[act_r];
					cur_cnt_r[act_r]  <= base_cnt_r[act_r];
				end else begin
					cur_addr_r[act_r] <= act_addr + 16'h0001;
					cur_cnt_r[act_r]  <= cur_cnt_r[act_r] - 16'h0001;
				end
			end
			if (wr && !off[3]) begin
				if (off[0]) begin
					base_cnt_r[ch_w][{ptr_r[ctl], 3'h0}+:8] <= io_wdata;
					cur_cnt_r[ch_w][{ptr_r[ctl], 3'h0}+:8]  <= io_wdata;
				end else begin
					base_addr_r[ch_w][{ptr_r[ctl], 3'h0}+:8] <= io_wdata;
					cur_addr_r[ch_w][{ptr_r[ctl], 3'h0}+:8]  <= io_wdata;
				end
			end
		end
	end

	// ****************************************
	// Mode, command, mask, status
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 8; i++) begin
				mode_r[i] <= MODE_RESET;
			end
		end else if (wr && off == OFF_MODE) begin
			mode_r[ch_d] <= {io_wdata[7:6], io_wdata[4], io_wdata[3:2]};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmd_dis_r <= 2'h0;
		end else if (wr && off == OFF_CMD_STAT) begin
			cmd_dis_r[ctl] <= io_wdata[CMD_DIS_BIT];
		end else if (wr && off == OFF_MCLR) begin
			cmd_dis_r[ctl] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_r <= {MASK_RESET, MASK_RESET};
		end else begin
			if (wr && off == OFF_SMASK) begin
				mask_r[ch_d] <= io_wdata[MASK_SET_BIT];
			end else if (wr && off == OFF_ALL_MASK) begin
				mask_r[{ctl, 2'h0}+:4] <= io_wdata[3:0];
			end else if (wr && off == OFF_CLR_MASK) begin
				mask_r[{ctl, 2'h0}+:4] <= 4'h0;
			end else if (wr && off == OFF_MCLR) begin
				mask_r[{ctl, 2'h0}+:4] <= MASK_RESET;
			end
			if (push && tc_now && !act_mode[M_AUTO]) begin
				mask_r[act_r] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tc_r <= 8'h00;
		end else begin
			if ((rd && off == OFF_CMD_STAT) || (wr && off == OFF_MCLR)) begin
				tc_r[{ctl, 2'h0}+:4] <= 4'h0;
			end
			if (push && tc_now) begin
				tc_r[act_r] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ptr_r <= 2'h0;
		end else if (wr && (off == OFF_CLR_PTR || off == OFF_MCLR)) begin
			ptr_r[ctl] <= 1'b0;
		end else if ((wr || rd) && !off[3]) begin
			ptr_r[ctl] <= !ptr_r[ctl];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= RDATA_RESET;
		end else if (rd) begin
			if (!off[3] && off[0]) begin
				rdata_r <= cur_cnt_r[ch_w][{ptr_r[ctl], 3'h0}+:8];
			end else if (!off[3]) begin
				rdata_r <= cur_addr_r[ch_w][{ptr_r[ctl], 3'h0}+:8];
			end else if (off == OFF_CMD_STAT) begin
				rdata_r <= {req_s_r[{ctl, 2'h0}+:4], tc_r[{ctl, 2'h0}+:4]};
			end else begin
				rdata_r <= RDATA_RESET;
			end
		end
	end

	assign io_rdata = rdata_r;

	// ****************************************
	// Service engine
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r    <= IDLE;
			act_r   <= 3'h0;
			grant_r <= 1'b0;
		end else begin
			case (st_r)
				IDLE: begin
					if (|elig) begin
						if (win == CASCADE_CH) begin
							st_r    <= MASTER;
							grant_r <= 1'b1;
						end else begin
							act_r <= win;
							st_r  <= XFER;
						end
					end
				end
				XFER: begin
					if (cmd_dis_r[act_r[2]] || mask_r[act_r]) begin
						st_r <= IDLE;
					end else if (push) begin
						// Ends on terminal count, any non-demand service or request drop, or on the mask or disable check above
						if (tc_now || act_mode[M_SVC+:2] != SVC_DEMAND || !req_s_r[act_r]) begin
							st_r <= IDLE;
						end
					end
				end
				MASTER: begin
					if (!elig[CASCADE_CH]) begin
						st_r    <= IDLE;
						grant_r <= 1'b0;
					end
				end
				default: begin
					st_r <= IDLE;
				end
			endcase
		end
	end

	assign bus_master_grant = grant_r;

	item_fifo #(.WIDTH(ITEM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.nrst     (nrst),
		.in_valid (st_r == XFER),
		.in_ready (in_ready),
		.in_data  (item),
		.out_valid(xfer_valid),
		.out_ready(xfer_ready),
		.out_data (out_item)
	);

	assign xfer_wide = out_item[22];
	assign xfer_last = out_item[21];
	assign xfer_type = out_item[20:19];
	assign xfer_chan = out_item[18:16];
	assign xfer_addr = out_item[15:0];

	// ****************************************
	// Checks
	// ****************************************
	sequence s_single_push;
		push && act_mode[M_SVC+:2] == SVC_SINGLE;
	endsequence

	sequence s_demand_go;
		push && act_mode[M_SVC+:2] == SVC_DEMAND && !tc_now && req_s_r[act_r] && !mask_r[act_r];
	endsequence

	a_single_one_item: assert property (s_single_push |=> st_r == IDLE)
		else $error("single service pushed more than one item");
	a_demand_burst: assert property (s_demand_go ##0 !cmd_dis_r[act_r[2]] |=> st_r == XFER)
		else $error("demand service stopped early");
	a_tc_flag_set: assert property (push && tc_now |=> tc_r[$past(act_r)])
		else $error("terminal count did not set status");
	a_autoinit_reload: assert property (push && tc_now && act_mode[M_AUTO] && !wr
		|=> cur_addr_r[$past(act_r)] == base_addr_r[$past(act_r)])
		else $error("auto-initialization did not reload");
	a_addr_upward: assert property (push && !tc_now && !wr |=> cur_addr_r[$past(act_r)] == $past(act_addr) + 16'h0001)
		else $error("address did not increment");
	a_ch4_cascade: assert property (st_r == IDLE && elig == 8'h10 |=> grant_r && st_r == MASTER)
		else $error("channel 4 request not granted as bus master");
	a_disabled_idle: assert property (st_r == IDLE && cmd_dis_r == 2'h3 |=> st_r == IDLE)
		else $error("disabled controller started service");
	a_fixed_priority: assert property (st_r == IDLE && elig[0] |=> st_r == XFER && act_r == 3'h0)
		else $error("channel 0 lost arbitration");
	a_item_width: assert property (xfer_valid |-> xfer_wide == xfer_chan[2] && xfer_chan != CASCADE_CH)
		else $error("item width or channel wrong");
	a_type_legal: assert property (push |-> push_type != TYPE_ILLEGAL)
		else $error("illegal transfer type issued");
	a_status_clear: assert property (rd && off == OFF_CMD_STAT && !ctl && !push |=> tc_r[3:0] == 4'h0)
		else $error("status read did not clear flags");

endmodule : legacy_transfer_controller

// ---- testbench/lpc_peer_model.sv ----
// Peripheral side: request lines and a transfer sink that stalls at random
`timescale 1ns/1ps

module lpc_peer_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Bench control
	input  wire logic [7:0] want,
	input  wire logic       stall,
	// Design side
	output logic [7:0]      dma_req,
	output logic            xfer_ready
);
	integer seed = 32'hdbc75229;

	initial begin
		dma_req = 8'h00;
		xfer_ready = 1'b0;
	end

	// Bit 4 asks for mastership only, never for data
	always @(negedge clk) begin
		dma_req <= want;
		xfer_ready <= !stall && nrst && (($random(seed) & 1) != 0);
	end
endmodule : lpc_peer_model

// ---- testbench/legacy_transfer_controller_tb.sv ----
// Self-checking bench for the legacy transfer controller
`timescale 1ns/1ps

module legacy_transfer_controller_tb;
	import dma_pkg::*;
	logic              clk, nrst, io_wr, io_rd, stall;
	logic [15:0]       io_addr, xfer_addr;
	logic [7:0]        io_wdata, io_rdata, dma_req, want;
	logic              xfer_valid, xfer_ready, xfer_wide, xfer_last, bus_master_grant;
	logic [2:0]        xfer_chan;
	logic [1:0]        xfer_type;
	logic [ITEM_W-1:0] q[$];
	logic [ITEM_W-1:0] rep, ex;
	int                fail_count, checked, cycles, i;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	legacy_transfer_controller DUT (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .dma_req(dma_req), .xfer_valid(xfer_valid),
		.xfer_ready(xfer_ready), .xfer_addr(xfer_addr), .xfer_chan(xfer_chan), .xfer_type(xfer_type),
		.xfer_wide(xfer_wide), .xfer_last(xfer_last), .bus_master_grant(bus_master_grant));
	lpc_peer_model peer (.clk(clk), .nrst(nrst), .want(want), .stall(stall), .dma_req(dma_req),
		.xfer_ready(xfer_ready));

	// ****************************************
	// Checking and reporting
	// ****************************************
	task print_verdict;
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val

	task chk_item(input logic [ITEM_W-1:0] e, input logic [ITEM_W-1:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch item expected %h seen %h", e, g);
		end
	endtask : chk_item

	function automatic logic [ITEM_W-1:0] mk(input logic [15:0] a, input logic [2:0] c, input logic [1:0] t,
		input logic w, input logic l);
		return {a, c, t, w, l};
	endfunction : mk

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
	endtask : wr

	task rd(input logic [15:0] a, input logic [7:0] e, input string nm);
		@(negedge clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
		@(negedge clk);
		chk_val(nm, {8'h00, e}, {8'h00, io_rdata});
	endtask : rd

	task drain;
		for (int k = 0; k < 300 && q.size() > 0; k++)
			@(negedge clk);
		chk_val("left", 16'h0000, 16'(q.size()));
	endtask : drain

	// Model queue first, then the steady repeat item
	always @(posedge clk) begin
		if (nrst === 1'b1 && xfer_valid === 1'b1 && xfer_ready === 1'b1) begin
			ex = (q.size() > 0) ? q.pop_front() : rep;
			chk_item(ex, {xfer_addr, xfer_chan, xfer_type, xfer_wide, xfer_last});
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		want = 8'h00;
		stall = 1'b1;
		rep = '1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		rd(16'h0008, 8'h00, "status");
		rd(16'h0009, 8'h00, "request");
		wr(16'h0310, 8'hFF);
		rd(16'h0300, 8'h00, "unmapped");
		// Demand burst of twelve items, bit 5 set, sink stalled to fill the FIFO
		wr(16'h0002, 8'h34);
		wr(16'h0002, 8'h12);
		wr(16'h0003, 8'h0B);
		wr(16'h0003, 8'h00);
		wr(16'h000B, 8'h25);
		for (i = 0; i < 12; i++)
			q.push_back(mk(16'h1234 + 16'(i), 3'h1, TYPE_WRITE, 1'b0, i == 11));
		wr(16'h000A, 8'h01);
		want = 8'h02;
		repeat (40) @(negedge clk);
		chk_val("valid", 16'h0001, {15'h0, xfer_valid});
		stall = 1'b0;
		drain;
		repeat (10) @(negedge clk);
		rd(16'h0008, 8'h22, "status");
		rd(16'h0008, 8'h20, "status");
		want = 8'h00;
		wr(16'h000C, 8'h00);
		rd(16'h0002, 8'h40, "addr lo");
		rd(16'h0002, 8'h12, "addr hi");
		// Channel 4 asks for mastership
		wr(16'h00D4, 8'h00);
		want = 8'h10;
		for (i = 0; i < 10 && bus_master_grant !== 1'b1; i++)
			@(negedge clk);
		chk_val("grant", 16'h0001, {15'h0, bus_master_grant});
		want = 8'h00;
		repeat (6) @(negedge clk);
		chk_val("grant", 16'h0000, {15'h0, bus_master_grant});
		// Channel 0 single beats channel 5, which repeats by auto-init
		wr(16'h0000, 8'h50);
		wr(16'h0000, 8'h00);
		wr(16'h0001, 8'h00);
		wr(16'h0001, 8'h00);
		wr(16'h000B, 8'h40);
		wr(16'h00C4, 8'h00);
		wr(16'h00C4, 8'h01);
		wr(16'h00C6, 8'h00);
		wr(16'h00C6, 8'h00);
		wr(16'h00D6, 8'h59);
		q.push_back(mk(16'h0050, 3'h0, TYPE_VERIFY, 1'b0, 1'b1));
		rep = mk(16'h0100, 3'h5, TYPE_READ, 1'b1, 1'b1);
		wr(16'h000A, 8'h00);
		wr(16'h00D4, 8'h01);
		want = 8'h21;
		repeat (60) @(negedge clk);
		chk_val("left", 16'h0000, 16'(q.size()));
		wr(16'h00D0, 8'h04);
		repeat (40) @(negedge clk);
		rep = '1;
		repeat (20) @(negedge clk);
		chk_val("valid", 16'h0000, {15'h0, xfer_valid});
		rd(16'h00D0, 8'h22, "status");
		print_verdict;
	end
endmodule : legacy_transfer_controller_tb
